// ===== hw/ssb_pkg.sv
// package: settings byte map, field positions, reset values and decoded setting types
package ssb_pkg;

  // --------------------------------------------------------------------
  // settings byte indices
  // --------------------------------------------------------------------
  localparam logic [5:0] IDX_FIRST_ANALOG = 6'h01;
  localparam logic [5:0] IDX_SECOND_ANALOG = 6'h02;
  localparam logic [5:0] IDX_LOGIC = 6'h03;
  localparam logic [5:0] IDX_LOGIC_MASK = 6'h04;
  localparam logic [5:0] IDX_TRIGGER = 6'h05;
  localparam logic [5:0] IDX_CURSOR = 6'h06;
  localparam logic [5:0] IDX_DISPLAY = 6'h07;
  localparam logic [5:0] IDX_SPECTRUM = 6'h08;
  localparam logic [5:0] IDX_SWEEP = 6'h09;
  localparam logic [5:0] IDX_SNIFFER = 6'h0a;
  localparam logic [5:0] IDX_STATUS = 6'h0b;
  localparam logic [5:0] IDX_SETTINGS_LAST = 6'h2b;
  localparam logic [5:0] ACQ_AUTO_BELOW = 6'h0e;
  localparam logic [5:0] GEN_AUTO_ABOVE = 6'h22;

  // --------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------
  localparam logic [7:0] SSB_RST_BYTE = 8'h00;
  localparam logic [3:0] SSB_RST_FLAGS = 4'h0;
  localparam logic [1:0] SSB_RST_METER = 2'h0;

  // --------------------------------------------------------------------
  // field positions, one or two lines per byte
  // --------------------------------------------------------------------
  localparam int unsigned AN_ON = 0, AN_INV = 4, AN_AVG = 5, AN_MATH = 6, AN_SUB = 7;
  localparam int unsigned LG_ON = 0, LG_PULL = 1, LG_PUP = 2, LG_LOW = 3, LG_INV = 4, LG_SER = 5, LG_PAR = 6;
  localparam int unsigned LG_ASCII = 7;
  localparam int unsigned TR_NORM = 0, TR_SINGLE = 1, TR_AUTO = 2, TR_DIR = 3, TR_ROUND = 4;
  localparam int unsigned TR_SLOPE = 5, TR_WIN = 6, TR_EDGE = 7;
  localparam int unsigned CU_ROLL = 0, CU_AUTO = 1, CU_TRACK = 2, CU_HFIRST = 3, CU_HSECOND = 4;
  localparam int unsigned CU_VERT = 5, CU_REF = 6, CU_SINGLE = 7;
  localparam int unsigned DI_GRID_LO = 0, DI_ELASTIC = 2, DI_INV = 3, DI_FLIP = 4, DI_PERSIST = 5;
  localparam int unsigned DI_LINE = 6, DI_SHOW = 7;
  localparam int unsigned SP_HAMMING = 0, SP_HANN = 1, SP_BLACKMAN = 2, SP_LOG = 3, SP_IQ = 4;
  localparam int unsigned SP_SCOPE = 5, SP_XY = 6, SP_SPECTRUM = 7;
  localparam int unsigned SW_ACC_DIR = 0, SW_ACC = 1, SW_DIR = 2, SW_PINGPONG = 3, SW_FREQ = 4;
  localparam int unsigned SW_AMP = 5, SW_OFFSET = 6, SW_DUTY = 7;
  localparam int unsigned SN_BAUD_LO = 0, SN_LEN_LO = 3, SN_OPT_A = 5, SN_OPT_B = 6, SN_OPT_C = 7;
  localparam int unsigned ST_EXIT = 0, ST_UPD_GEN = 1, ST_UPD_ACQ = 2, ST_SNIFF = 3;
  localparam int unsigned ST_STOPPED = 4, ST_TRIGGERED = 5, ST_METER_LO = 6;

  // --------------------------------------------------------------------
  // decoded choices
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    GRID_NONE = 2'b00, GRID_DOTS = 2'b01, GRID_FOLLOW = 2'b10, GRID_FULL = 2'b11
  } ssb_grid_type;
  typedef enum logic [1:0] {
    METER_FREQ = 2'b00, METER_VDC = 2'b01, METER_VPP = 2'b10, METER_PULSES = 2'b11
  } ssb_meter_type;
  typedef enum logic [2:0] {
    BAUD_1200 = 3'b000, BAUD_2400 = 3'b001, BAUD_4800 = 3'b010, BAUD_9600 = 3'b011,
    BAUD_19200 = 3'b100, BAUD_38400 = 3'b101, BAUD_57600 = 3'b110, BAUD_115200 = 3'b111
  } ssb_baud_type;
  typedef enum logic [1:0] {
    LEN_5 = 2'b00, LEN_6 = 2'b01, LEN_7 = 2'b10, LEN_8 = 2'b11
  } ssb_len_type;

  // decoded view of every bitfield, index 0 is the first analog channel
  typedef struct packed {
    logic [1:0] ch_on, ch_invert, ch_average, math_en, math_subtract;
    logic logic_on, pull_en, pull_up, thick_low, logic_invert, serial_decode, parallel_decode, ascii_sniff;
    logic trig_normal, trig_single, trig_auto, trig_dir, round_sniff, trig_slope, trig_window, trig_edge;
    logic trig_dual_edge;
    logic roll, auto_cursors, track_cursors, hcursor_first, hcursor_second, vcursor, ref_wave, single_capture;
    ssb_grid_type grid;
    logic elastic, disp_invert, flip, persist, line_draw, show_settings;
    logic win_hamming, win_hann, win_blackman, vlog, iq_view, view_scope, view_xy, view_spectrum, view_meter;
    logic accel_dir, accel_sweep, sweep_dir, ping_pong, sweep_freq, sweep_amp, sweep_offset, sweep_duty;
    ssb_baud_type baud;
    ssb_len_type data_len;
    logic parity_en, parity_odd, two_stop, ss_invert, clk_polarity, clock_phase_select;
    logic exit_trigger, update_generator, update_acquisition, enter_sniffer;
    ssb_meter_type meter;
  } ssb_cfg_type;

endpackage : ssb_pkg

// ===== hw/ssb_settings_bitfields.sv
// module: byte-wide settings store with bitfield decode and status flags
module ssb_settings_bitfields
  import ssb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [5:0] wr_index,
  input wire logic [7:0] wr_data,
  input wire logic [5:0] rd_index,
  output logic [7:0] rd_data,
  input wire logic exit_trigger_done,
  input wire logic gen_update_done,
  input wire logic acq_update_done,
  input wire logic sniffer_entered,
  input wire logic scope_stopped,
  input wire logic scope_triggered,
  output ssb_cfg_type cfg
);

  // --------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------
  logic [7:0] bytes_ff [IDX_FIRST_ANALOG:IDX_SNIFFER]; // plain bitfield bytes
  logic [3:0] flags_ff; // request flags, status bits 3:0
  logic [3:0] nxt_flags;
  logic [3:0] flag_set; // hardware or host sets
  logic [3:0] flag_clr; // acknowledges from the engines
  logic [1:0] meter_ff; // status bits 7:6
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;
  ssb_cfg_type cfg_ff;
  ssb_cfg_type nxt_cfg;
  // the registered decode costs a cycle of latency but keeps every setting glitch free
  logic wr_ok; // write inside the 44 byte settings space
  logic status_wr;
  logic acq_auto;
  logic gen_auto;

  // indices past the last settings byte are ignored entirely
  assign wr_ok = wr_en && (wr_index <= IDX_SETTINGS_LAST);
  assign status_wr = wr_ok && (wr_index == IDX_STATUS);
  assign acq_auto = wr_ok && (wr_index < ACQ_AUTO_BELOW);
  assign gen_auto = wr_ok && (wr_index > GEN_AUTO_ABOVE);

  // --------------------------------------------------------------------
  // byte writes
  // --------------------------------------------------------------------
  // one register per bitfield byte; the logic mask byte rides along as a plain byte
  // index 0 and 12 to 43 are not stored here; writes to 0, 12, 13 and 35 to 43 only raise update flags, writes to 14 to 34 do nothing
  for (genvar k = int'(IDX_FIRST_ANALOG); k <= int'(IDX_SNIFFER); k++) begin : g_byte
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        bytes_ff[k] <= SSB_RST_BYTE;
      end else if (wr_ok && (wr_index == 6'(k))) begin
        bytes_ff[k] <= wr_data;
      end
    end
  end

  // --------------------------------------------------------------------
  // status request flags
  // --------------------------------------------------------------------
  // a set in the same cycle as an acknowledge wins, so no request is lost
  // a done pulse with no pending flag is harmless
  always_comb begin
    flag_set = status_wr ? wr_data[3:0] : 4'h0;
    flag_set[ST_UPD_ACQ] = flag_set[ST_UPD_ACQ] | acq_auto;
    flag_set[ST_UPD_GEN] = flag_set[ST_UPD_GEN] | gen_auto;
    flag_clr = 4'h0;
    flag_clr[ST_EXIT] = exit_trigger_done;
    flag_clr[ST_UPD_GEN] = gen_update_done;
    flag_clr[ST_UPD_ACQ] = acq_update_done;
    flag_clr[ST_SNIFF] = sniffer_entered;
    // a host write of the status byte overrides the held flags, zeros included, except update acquisition, which the write always sets
    nxt_flags = flag_set | (status_wr ? 4'h0 : (flags_ff & ~flag_clr));
  end

  // flags hold until the engine that serves them acknowledges or a host status write replaces them
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags_ff <= SSB_RST_FLAGS;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // meter function bits are plain host settings
  // bits 5:4 of a status write are ignored, those bits are live
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meter_ff <= SSB_RST_METER;
    end else if (status_wr) begin
      meter_ff <= wr_data[ST_METER_LO +: 2];
    end
  end

  // --------------------------------------------------------------------
  // read back
  // --------------------------------------------------------------------
  // stopped and triggered come live from the scope core, not from storage
  // unmapped indices, 0 and 12 upward, read back as zero
  always_comb begin
    nxt_rd_data = 8'h00;
    if (rd_index == IDX_STATUS) begin
      nxt_rd_data = {meter_ff, scope_triggered, scope_stopped, flags_ff};
    end else if ((rd_index >= IDX_FIRST_ANALOG) && (rd_index <= IDX_SNIFFER)) begin
      nxt_rd_data = bytes_ff[rd_index];
    end
  end

  // registered read, one cycle after the index
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data_ff <= SSB_RST_BYTE;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end
  assign rd_data = rd_data_ff;

  // --------------------------------------------------------------------
  // bitfield decode
  // --------------------------------------------------------------------
  // decode is registered so every setting output leaves a flop
  always_comb begin
    nxt_cfg = '0;
    // analog channels; bits 1 to 3 are reserved and decode to nothing
    for (int c = 0; c < 2; c++) begin
      nxt_cfg.ch_on[c] = bytes_ff[int'(IDX_FIRST_ANALOG) + c][AN_ON];
      nxt_cfg.ch_invert[c] = bytes_ff[int'(IDX_FIRST_ANALOG) + c][AN_INV];
      nxt_cfg.ch_average[c] = bytes_ff[int'(IDX_FIRST_ANALOG) + c][AN_AVG];
      nxt_cfg.math_en[c] = bytes_ff[int'(IDX_FIRST_ANALOG) + c][AN_MATH];
      nxt_cfg.math_subtract[c] = bytes_ff[int'(IDX_FIRST_ANALOG) + c][AN_SUB];
    end
    // logic inputs
    nxt_cfg.logic_on = bytes_ff[IDX_LOGIC][LG_ON];
    nxt_cfg.pull_en = bytes_ff[IDX_LOGIC][LG_PULL];
    nxt_cfg.pull_up = bytes_ff[IDX_LOGIC][LG_PUP];
    nxt_cfg.thick_low = bytes_ff[IDX_LOGIC][LG_LOW];
    nxt_cfg.logic_invert = bytes_ff[IDX_LOGIC][LG_INV];
    nxt_cfg.serial_decode = bytes_ff[IDX_LOGIC][LG_SER];
    nxt_cfg.parallel_decode = bytes_ff[IDX_LOGIC][LG_PAR];
    nxt_cfg.ascii_sniff = bytes_ff[IDX_LOGIC][LG_ASCII];
    // trigger; single without normal is passed through, the host must not send it
    nxt_cfg.trig_normal = bytes_ff[IDX_TRIGGER][TR_NORM];
    nxt_cfg.trig_single = bytes_ff[IDX_TRIGGER][TR_SINGLE];
    nxt_cfg.trig_auto = bytes_ff[IDX_TRIGGER][TR_AUTO];
    nxt_cfg.trig_dir = bytes_ff[IDX_TRIGGER][TR_DIR];
    nxt_cfg.round_sniff = bytes_ff[IDX_TRIGGER][TR_ROUND];
    nxt_cfg.trig_slope = bytes_ff[IDX_TRIGGER][TR_SLOPE];
    nxt_cfg.trig_window = bytes_ff[IDX_TRIGGER][TR_WIN];
    nxt_cfg.trig_edge = bytes_ff[IDX_TRIGGER][TR_EDGE];
    nxt_cfg.trig_dual_edge = bytes_ff[IDX_TRIGGER][TR_EDGE:TR_SLOPE] == 3'h0;
    // cursors; both horizontal bits are not guarded, the host keeps them exclusive
    nxt_cfg.roll = bytes_ff[IDX_CURSOR][CU_ROLL];
    nxt_cfg.auto_cursors = bytes_ff[IDX_CURSOR][CU_AUTO];
    nxt_cfg.track_cursors = bytes_ff[IDX_CURSOR][CU_TRACK];
    nxt_cfg.hcursor_first = bytes_ff[IDX_CURSOR][CU_HFIRST];
    nxt_cfg.hcursor_second = bytes_ff[IDX_CURSOR][CU_HSECOND];
    nxt_cfg.vcursor = bytes_ff[IDX_CURSOR][CU_VERT];
    nxt_cfg.ref_wave = bytes_ff[IDX_CURSOR][CU_REF];
    nxt_cfg.single_capture = bytes_ff[IDX_CURSOR][CU_SINGLE];
    // display
    nxt_cfg.grid = ssb_grid_type'(bytes_ff[IDX_DISPLAY][DI_GRID_LO +: 2]);
    nxt_cfg.elastic = bytes_ff[IDX_DISPLAY][DI_ELASTIC];
    nxt_cfg.disp_invert = bytes_ff[IDX_DISPLAY][DI_INV];
    nxt_cfg.flip = bytes_ff[IDX_DISPLAY][DI_FLIP];
    nxt_cfg.persist = bytes_ff[IDX_DISPLAY][DI_PERSIST];
    nxt_cfg.line_draw = bytes_ff[IDX_DISPLAY][DI_LINE];
    nxt_cfg.show_settings = bytes_ff[IDX_DISPLAY][DI_SHOW];
    // spectrum windows are passed as stored; more than one is a host fault
    nxt_cfg.win_hamming = bytes_ff[IDX_SPECTRUM][SP_HAMMING];
    nxt_cfg.win_hann = bytes_ff[IDX_SPECTRUM][SP_HANN];
    nxt_cfg.win_blackman = bytes_ff[IDX_SPECTRUM][SP_BLACKMAN];
    nxt_cfg.vlog = bytes_ff[IDX_SPECTRUM][SP_LOG];
    nxt_cfg.iq_view = bytes_ff[IDX_SPECTRUM][SP_IQ];
    nxt_cfg.view_scope = bytes_ff[IDX_SPECTRUM][SP_SCOPE];
    nxt_cfg.view_xy = bytes_ff[IDX_SPECTRUM][SP_XY];
    nxt_cfg.view_spectrum = bytes_ff[IDX_SPECTRUM][SP_SPECTRUM];
    nxt_cfg.view_meter = bytes_ff[IDX_SPECTRUM][SP_SPECTRUM:SP_SCOPE] == 3'h0;
    // generator sweep
    nxt_cfg.accel_dir = bytes_ff[IDX_SWEEP][SW_ACC_DIR];
    nxt_cfg.accel_sweep = bytes_ff[IDX_SWEEP][SW_ACC];
    nxt_cfg.sweep_dir = bytes_ff[IDX_SWEEP][SW_DIR];
    nxt_cfg.ping_pong = bytes_ff[IDX_SWEEP][SW_PINGPONG];
    nxt_cfg.sweep_freq = bytes_ff[IDX_SWEEP][SW_FREQ];
    nxt_cfg.sweep_amp = bytes_ff[IDX_SWEEP][SW_AMP];
    nxt_cfg.sweep_offset = bytes_ff[IDX_SWEEP][SW_OFFSET];
    nxt_cfg.sweep_duty = bytes_ff[IDX_SWEEP][SW_DUTY];
    // sniffer; upper bits carry uart and spi meanings side by side
    nxt_cfg.baud = ssb_baud_type'(bytes_ff[IDX_SNIFFER][SN_BAUD_LO +: 3]);
    nxt_cfg.data_len = ssb_len_type'(bytes_ff[IDX_SNIFFER][SN_LEN_LO +: 2]);
    nxt_cfg.parity_en = bytes_ff[IDX_SNIFFER][SN_OPT_A];
    nxt_cfg.parity_odd = bytes_ff[IDX_SNIFFER][SN_OPT_B];
    nxt_cfg.two_stop = bytes_ff[IDX_SNIFFER][SN_OPT_C];
    nxt_cfg.ss_invert = bytes_ff[IDX_SNIFFER][SN_OPT_A];
    nxt_cfg.clk_polarity = bytes_ff[IDX_SNIFFER][SN_OPT_B];
    nxt_cfg.clock_phase_select = bytes_ff[IDX_SNIFFER][SN_OPT_C];
    // status requests and meter function
    nxt_cfg.exit_trigger = flags_ff[ST_EXIT];
    nxt_cfg.update_generator = flags_ff[ST_UPD_GEN];
    nxt_cfg.update_acquisition = flags_ff[ST_UPD_ACQ];
    nxt_cfg.enter_sniffer = flags_ff[ST_SNIFF];
    nxt_cfg.meter = ssb_meter_type'(meter_ff);
  end

  // decoded settings register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= '0;
      // zero bytes decode to dual edge and meter view, so reset shows the same
      cfg_ff.trig_dual_edge <= 1'h1;
      cfg_ff.view_meter <= 1'h1;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end
  assign cfg = cfg_ff;

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_math;
    wr_en && wr_index == IDX_SECOND_ANALOG |-> ##2 cfg.math_subtract[1] == $past(wr_data[7], 2);
  endproperty
  a_math: assert property (p_math) else $error("math operation bit wrong");
  property p_chan;
    wr_en && wr_index == IDX_FIRST_ANALOG |-> ##2 cfg.ch_average[0] == $past(wr_data[5], 2);
  endproperty
  a_chan: assert property (p_chan) else $error("average bit wrong");
  property p_pull;
    wr_en && wr_index == IDX_LOGIC |-> ##2 (cfg.pull_up == $past(wr_data[2], 2)) && (cfg.pull_en == $past(wr_data[1], 2));
  endproperty
  a_pull: assert property (p_pull) else $error("pull decode wrong");
  property p_ascii;
    wr_en && wr_index == IDX_LOGIC |-> ##2 cfg.ascii_sniff == $past(wr_data[7], 2);
  endproperty
  a_ascii: assert property (p_ascii) else $error("ascii bit wrong");
  property p_dual;
    cfg.trig_dual_edge == !(cfg.trig_slope || cfg.trig_window || cfg.trig_edge);
  endproperty
  a_dual: assert property (p_dual) else $error("dual edge decode wrong");
  property p_trig;
    wr_en && wr_index == IDX_TRIGGER |-> ##2 cfg.trig_window == $past(wr_data[6], 2);
  endproperty
  a_trig: assert property (p_trig) else $error("window trigger bit wrong");
  property p_cursor;
    wr_en && wr_index == IDX_CURSOR |-> ##2 cfg.single_capture == $past(wr_data[7], 2);
  endproperty
  a_cursor: assert property (p_cursor) else $error("capture bit wrong");
  property p_grid;
    wr_en && wr_index == IDX_DISPLAY |-> ##2 cfg.grid == ssb_grid_type'($past(wr_data[1:0], 2));
  endproperty
  a_grid: assert property (p_grid) else $error("grid decode wrong");
  property p_line;
    wr_en && wr_index == IDX_DISPLAY |-> ##2 cfg.line_draw == $past(wr_data[6], 2);
  endproperty
  a_line: assert property (p_line) else $error("line mode bit wrong");
  property p_meter_view;
    cfg.view_meter |-> !cfg.view_scope && !cfg.view_xy && !cfg.view_spectrum;
  endproperty
  a_meter_view: assert property (p_meter_view) else $error("meter view decode wrong");
  property p_sweep;
    wr_en && wr_index == IDX_SWEEP |-> ##2 cfg.ping_pong == $past(wr_data[3], 2);
  endproperty
  a_sweep: assert property (p_sweep) else $error("ping pong bit wrong");
  property p_baud;
    wr_en && wr_index == IDX_SNIFFER |-> ##2 cfg.baud == ssb_baud_type'($past(wr_data[2:0], 2));
  endproperty
  a_baud: assert property (p_baud) else $error("baud decode wrong");
  property p_len;
    wr_en && wr_index == IDX_SNIFFER |-> ##2 cfg.data_len == ssb_len_type'($past(wr_data[4:3], 2));
  endproperty
  a_len: assert property (p_len) else $error("data length decode wrong");
  property p_serial_opts;
    cfg.parity_en == cfg.ss_invert && cfg.parity_odd == cfg.clk_polarity && cfg.two_stop == cfg.clock_phase_select;
  endproperty
  a_serial_opts: assert property (p_serial_opts) else $error("uart and spi options differ");
  property p_stop_bits;
    wr_en && wr_index == IDX_SNIFFER |-> ##2 cfg.two_stop == $past(wr_data[7], 2);
  endproperty
  a_stop_bits: assert property (p_stop_bits) else $error("stop bit decode wrong");
  property p_set_wins;
    wr_en && wr_index < ACQ_AUTO_BELOW && acq_update_done |=> flags_ff[ST_UPD_ACQ] ##1 cfg.update_acquisition;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("acquisition request lost");
  property p_status_read;
    rd_index == IDX_STATUS |=> rd_data[5:4] == {$past(scope_triggered), $past(scope_stopped)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status readback wrong");
  property p_meter_fn;
    wr_en && wr_index == IDX_STATUS |-> ##2 cfg.meter == ssb_meter_type'($past(wr_data[7:6], 2));
  endproperty
  a_meter_fn: assert property (p_meter_fn) else $error("meter function wrong");
  property p_gen_auto;
    wr_en && wr_index > GEN_AUTO_ABOVE && wr_index <= IDX_SETTINGS_LAST |=> flags_ff[ST_UPD_GEN];
  endproperty
  a_gen_auto: assert property (p_gen_auto) else $error("generator update not flagged");
  property p_acq_auto;
    wr_en && wr_index < ACQ_AUTO_BELOW |=> flags_ff[ST_UPD_ACQ];
  endproperty
  a_acq_auto: assert property (p_acq_auto) else $error("acquisition update not flagged");
  property p_exit_clear;
    flags_ff[ST_EXIT] && exit_trigger_done && !status_wr |=> !flags_ff[ST_EXIT];
  endproperty
  a_exit_clear: assert property (p_exit_clear) else $error("exit request not cleared");

  // covers: scenarios for the bench to reach; the bench never reaches c_meter_mode or c_collision
  c_single_normal: cover property (wr_en && wr_index == IDX_TRIGGER && wr_data[1:0] == 2'b11);
  c_meter_mode: cover property (cfg.view_meter && cfg.meter == METER_PULSES);
  c_collision: cover property (gen_auto && gen_update_done);
  c_trig_readback: cover property (rd_index == IDX_STATUS && scope_triggered);
  c_sniff_req: cover property (cfg.enter_sniffer && cfg.exit_trigger);

endmodule : ssb_settings_bitfields

// ===== bench/ssb_core_model.sv
// partner model: scope core that acknowledges pending status requests after a delay
module ssb_core_model
  import ssb_pkg::*;
#(
  parameter int unsigned ACK_DELAY = 40 // slow, so the bench sees requests pending
) (
  input wire logic ref_clk,
  input wire logic rst,
  input ssb_cfg_type cfg,
  output logic [3:0] done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] req; // pending requests as the core sees them
  logic [7:0] wait_ff; // cycles spent on the current batch
  assign req = {cfg.enter_sniffer, cfg.update_acquisition, cfg.update_generator, cfg.exit_trigger};
  // --------------------------------------------------------------------
  // acknowledge: one pulse per batch, then the count restarts
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_ff <= 8'h00;
      done <= 4'h0;
    end else if (done != 4'h0 || req == 4'h0) begin // flags fall a while after the pulse
      wait_ff <= 8'h00;
      done <= 4'h0;
    end else begin
      wait_ff <= wait_ff + 8'h01;
      if (wait_ff == 8'(ACK_DELAY)) begin
        done <= req;
      end
    end
  end
endmodule : ssb_core_model

// ===== bench/test_ssb_settings_bitfields.sv
// testbench: settings writes and reads with checks of decoded fields and status flags
module test_ssb_settings_bitfields
  import ssb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, rst = 1'b1, wr_en = 1'b0, stopped = 1'b0, trig = 1'b0;
  logic [5:0] wr_index = 6'h00, rd_index = 6'h00;
  logic [7:0] wr_data = 8'h00, rd_data, d;
  logic [3:0] done;
  logic [3:0] g;
  ssb_cfg_type cfg;
  int error_cnt = 0, checked = 0;
  logic [7:0] tv [3] = '{8'h83, 8'h7C, 8'h1F}; // single always comes with normal
  logic [5:0] bi [5] = '{6'h2c, 6'h0e, 6'h22, 6'h0d, 6'h23}; // write index boundaries
  logic [7:0] be [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h03};
  always #2.5 ref_clk = ~ref_clk;
  ssb_settings_bitfields dut (.ref_clk(ref_clk), .rst(rst), .wr_en(wr_en), .wr_index(wr_index),
    .wr_data(wr_data), .rd_index(rd_index), .rd_data(rd_data), .exit_trigger_done(done[0]),
    .gen_update_done(done[1]), .acq_update_done(done[2]), .sniffer_entered(done[3]),
    .scope_stopped(stopped), .scope_triggered(trig), .cfg(cfg));
  ssb_core_model core (.ref_clk(ref_clk), .rst(rst), .cfg(cfg), .done(done));
  // --------------------------------------------------------------------
  // access tasks
  // --------------------------------------------------------------------
  task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one byte, then wait until the decode has settled
  task wr(input logic [5:0] idx, input logic [7:0] dat);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    wr_index <= idx;
    wr_data <= dat;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : wr
  task rd(input logic [5:0] idx, input logic [7:0] exp);
    @(posedge ref_clk);
    rd_index <= idx;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(rd_data, exp, "rd_data");
  endtask : rd
  task end_sim();
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    end_sim();
  end
  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({cfg.trig_dual_edge, cfg.view_meter, cfg.grid, cfg.baud, 1'b0}, 8'hC0, "reset");
    wr(IDX_FIRST_ANALOG, 8'hC0);
    chk({cfg.math_subtract, cfg.math_en, cfg.ch_average, cfg.ch_invert}, 8'h50, "math");
    wr(IDX_SECOND_ANALOG, 8'h31);
    chk({cfg.ch_on, cfg.ch_invert, cfg.ch_average, cfg.math_en}, 8'hA9, "analog");
    rd(IDX_SECOND_ANALOG, 8'h31);
    wr(IDX_LOGIC, 8'hFA);
    chk({cfg.ascii_sniff, cfg.parallel_decode, cfg.serial_decode, cfg.logic_invert, cfg.thick_low,
      cfg.pull_up, cfg.pull_en, cfg.logic_on}, 8'hFA, "logic");
    foreach (tv[i]) begin
      wr(IDX_TRIGGER, tv[i]);
      chk({cfg.trig_edge, cfg.trig_window, cfg.trig_slope, cfg.round_sniff, cfg.trig_dir, cfg.trig_auto,
        cfg.trig_single, cfg.trig_normal}, tv[i], "trigger");
      chk({7'h00, cfg.trig_dual_edge}, {7'h00, tv[i][7:5] == 3'b000}, "dual");
    end
    wr(IDX_CURSOR, 8'hEF);
    chk({cfg.single_capture, cfg.ref_wave, cfg.vcursor, cfg.hcursor_second, cfg.hcursor_first,
      cfg.track_cursors, cfg.auto_cursors, cfg.roll}, 8'hEF, "cursor");
    for (g = 4'h0; g < 4'h4; g++) begin
      d = {g[1:0], {4{g[0]}}, g[1:0]};
      wr(IDX_DISPLAY, d);
      chk({cfg.show_settings, cfg.line_draw, cfg.persist, cfg.flip, cfg.disp_invert, cfg.elastic,
        cfg.grid}, d, "display");
    end
    wr(IDX_SPECTRUM, 8'h1A);
    chk({cfg.view_meter, cfg.view_spectrum, cfg.view_xy, cfg.view_scope, cfg.iq_view, cfg.vlog,
      cfg.win_hann, cfg.win_hamming}, 8'h8E, "spectrum");
    wr(IDX_SPECTRUM, 8'hE4);
    chk({cfg.view_meter, cfg.view_spectrum, cfg.view_xy, cfg.view_scope, cfg.iq_view, cfg.vlog,
      cfg.win_blackman, cfg.win_hann}, 8'h72, "views");
    wr(IDX_SWEEP, 8'hA5);
    chk({cfg.sweep_duty, cfg.sweep_offset, cfg.sweep_amp, cfg.sweep_freq, cfg.ping_pong, cfg.sweep_dir,
      cfg.accel_sweep, cfg.accel_dir}, 8'hA5, "sweep");
    for (g = 4'h0; g < 4'h8; g++) begin
      d = {~g[0], g[1], g[2], g[1:0], g[2:0]};
      wr(IDX_SNIFFER, d);
      chk({cfg.baud, cfg.data_len, cfg.parity_en, cfg.parity_odd, cfg.two_stop},
        {d[2:0], d[4:3], d[5], d[6], d[7]}, "uart");
      chk({cfg.ss_invert, cfg.clk_polarity, cfg.clock_phase_select, 5'h00}, {d[5], d[6], d[7], 5'h00}, "spi");
    end
    repeat (60) @(posedge ref_clk);
    stopped <= 1'b1;
    for (g = 4'h0; g < 4'h4; g++) begin
      wr(IDX_STATUS, {g[1:0], 6'h00});
      chk({6'h00, cfg.meter}, {6'h00, g[1:0]}, "meter");
      @(posedge ref_clk);
      trig <= g[0];
      rd(IDX_STATUS, {g[1:0], g[0], 5'h14});
    end
    wr(IDX_STATUS, 8'h09);
    chk({4'h0, cfg.enter_sniffer, cfg.update_acquisition, cfg.update_generator, cfg.exit_trigger},
      8'h0D, "requests");
    repeat (60) @(posedge ref_clk);
    chk({4'h0, cfg.enter_sniffer, cfg.update_acquisition, cfg.update_generator, cfg.exit_trigger},
      8'h00, "acknowledged");
    foreach (bi[i]) begin
      wr(bi[i], 8'hFF);
      chk({6'h00, cfg.update_generator, cfg.update_acquisition}, be[i], "auto flags");
    end
    rd(6'h2c, 8'h00);
    end_sim();
  end
endmodule : test_ssb_settings_bitfields
